// file: hdl/bss_pkg.sv
// package for the burner start sequencer: register map, codes and timing
// Notes on behaviour
// - front switch on: require five interlocks closed
// - blocked inlet, blower proof not pre-checked
// - interlocks closed: ready lamp, enter standby
// - open interlock or unmet step reports fault
// - demand lights lamp, checks closure proof
// - purge start energises blower relay
// - purge: valve full open, expect purge switch
// - blower proof closed: purge status, count seconds
// - purge done: low fire, expect ignition switch
// - spark-only cleaning for 0, 2 or 7 s
// - gas valve on, pre-ignition, then trial status
// - no spark after 3 s aborts ignition
// - flame detection window at most 4 s
// - igniter off one second after flame
// - 2 s continuous flame proves fire, show strength
// - 5 s after proof show date and time
// - firing: loop drives valve, position displayed
// - demand end: gas, blower off, valve closed, standby
// - start and stop levels on requested position
package bss_pkg;

	localparam int unsigned CLOCK_HZ         = 50_000_000;
	localparam int unsigned SECOND_CYCLES    = CLOCK_HZ;

	// register byte offsets
	localparam logic [7:0]  REG_CONTROL      = 8'h00;
	localparam logic [7:0]  REG_PURGE_TIME   = 8'h04;
	localparam logic [7:0]  REG_LEVELS       = 8'h08;
	localparam logic [7:0]  REG_STATUS       = 8'h0c;
	localparam logic [7:0]  REG_FAULT        = 8'h10;
	localparam logic [7:0]  REG_POSITION     = 8'h14;

	// control fields
	localparam int unsigned CTL_CLEAN_LSB    = 0;
	localparam int unsigned CTL_LARGE_BIT    = 2;
	localparam int unsigned CTL_FAULT_CLR    = 3;
	localparam logic [1:0]  CLEAN_0S         = 2'h0;
	localparam logic [1:0]  CLEAN_2S         = 2'h1;
	localparam logic [1:0]  CLEAN_7S         = 2'h2;

	// timing in seconds
	localparam logic [7:0]  CLEAN_2S_SEC     = 8'h02;
	localparam logic [7:0]  CLEAN_7S_SEC     = 8'h07;
	localparam logic [7:0]  SPARK_LIMIT_SEC  = 8'h03;
	localparam logic [7:0]  FLAME_WINDOW_SEC = 8'h04;
	localparam logic [7:0]  IGNITER_OFF_SEC  = 8'h01;
	localparam logic [7:0]  FLAME_PROVE_SEC  = 8'h02;
	localparam logic [7:0]  STRENGTH_SEC     = 8'h05;
	localparam logic [7:0]  PURGE_DEF_SEC    = 8'h1e;

	// valve positions in percent
	localparam logic [6:0]  VALVE_FULL       = 7'h64;
	localparam logic [6:0]  VALVE_LOW_FIRE   = 7'h1e;
	localparam logic [6:0]  VALVE_CLOSED     = 7'h00;
	localparam logic [6:0]  START_SMALL      = 7'h18;
	localparam logic [6:0]  STOP_SMALL       = 7'h10;
	localparam logic [6:0]  START_LARGE      = 7'h14;
	localparam logic [6:0]  STOP_LARGE       = 7'h0e;

	// fault codes
	localparam logic [3:0]  FLT_NONE         = 4'h0;
	localparam logic [3:0]  FLT_CLOSURE      = 4'h1;
	localparam logic [3:0]  FLT_LOW_WATER    = 4'h2;
	localparam logic [3:0]  FLT_HIGH_TEMP    = 4'h3;
	localparam logic [3:0]  FLT_HIGH_GAS     = 4'h4;
	localparam logic [3:0]  FLT_LOW_GAS      = 4'h5;
	localparam logic [3:0]  FLT_NO_SPARK     = 4'h6;
	localparam logic [3:0]  FLT_NO_FLAME     = 4'h7;
	localparam logic [3:0]  FLT_PURGE_SW     = 4'h8;
	localparam logic [3:0]  FLT_BLOWER_PRF   = 4'h9;
	localparam logic [3:0]  FLT_IGN_SW       = 4'ha;
	localparam logic [3:0]  FLT_FLAME_LOST   = 4'hb;

	// display codes
	localparam logic [3:0]  DSP_OFF          = 4'h0;
	localparam logic [3:0]  DSP_STANDBY      = 4'h1;
	localparam logic [3:0]  DSP_PURGE        = 4'h2;
	localparam logic [3:0]  DSP_CLEANING     = 4'h3;
	localparam logic [3:0]  DSP_PRE_IGN      = 4'h4;
	localparam logic [3:0]  DSP_TRIAL        = 4'h5;
	localparam logic [3:0]  DSP_STRENGTH     = 4'h6;
	localparam logic [3:0]  DSP_DATE_TIME    = 4'h7;
	localparam logic [3:0]  DSP_FAULT        = 4'h8;
	localparam logic [3:0]  DSP_STARTING     = 4'h9;

	typedef struct packed {
		logic valve_closure_proof;
		logic low_water;
		logic high_temp;
		logic high_gas;
		logic low_gas;
		logic blocked_inlet;
		logic blower_proof;
		logic purge_switch;
		logic ignition_switch;
	} bss_switch_type;

	typedef struct packed {
		logic blower_relay;
		logic igniter_relay;
		logic gas_shutoff_valve;
		logic ready_lamp;
		logic demand_lamp;
	} bss_relay_type;

	typedef enum logic [8:0] {
		ST_OFF     = 9'h001,
		ST_STANDBY = 9'h002,
		ST_PURGE   = 9'h004,
		ST_IGN_POS = 9'h008,
		ST_CLEAN   = 9'h010,
		ST_PRE_IGN = 9'h020,
		ST_TRIAL   = 9'h040,
		ST_FIRING  = 9'h080,
		ST_FAULT   = 9'h100
	} bss_state_type;

endpackage

// file: hdl/bss_second_timer.sv
// seconds timer: one-cycle tick divider and a restartable second counter
`timescale 1ns/1ps
module bss_second_timer
	import bss_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SECOND_CYCLES
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// control
	input  wire logic       restart,
	// result
	output logic            tick,
	output logic [7:0]      seconds
);

	logic [31:0] divider;

	// restart realigns the divider so each count is a whole second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divider <= 32'h0;
		end else if (restart || divider == TICK_CYCLES - 1) begin
			divider <= 32'h0;
		end else begin
			divider <= divider + 32'h1;
		end
	end

	assign tick = !restart && (divider == TICK_CYCLES - 1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seconds <= 8'h0;
		end else if (restart) begin
			seconds <= 8'h0;
		end else if (tick && seconds != 8'hff) begin
			seconds <= seconds + 8'h1;
		end
	end

endmodule

// file: hdl/bss_sequencer.sv
// burner start sequencer with apb register access
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module bss_sequencer
	import bss_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SECOND_CYCLES
) (
	// clock and reset
	input  wire logic           clock,
	input  wire logic           rst_n,
	// apb slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	// operator and plant inputs
	input  wire logic           front_switch,
	input  wire logic           heat_demand,
	input  wire bss_switch_type switches,
	input  wire logic           spark_sense,
	input  wire logic           flame_sense,
	input  wire logic [7:0]     flame_strength,
	input  wire logic [6:0]     loop_position,
	input  wire logic [31:0]    date_time,
	// outputs to plant and panel
	output bss_relay_type       relays,
	output logic [6:0]          valve_command,
	output logic [6:0]          valve_display,
	output logic [3:0]          display_code,
	output logic [31:0]         display_value,
	output logic [3:0]          fault_code,
	output logic                purge_active_status,
	output logic                light_off_attempt_status,
	output logic                fire_confirmed_status
);

	bss_state_type state;
	bss_state_type next_state;
	logic [1:0]    clean_select;
	logic          large_model;
	logic [7:0]    purge_seconds;
	logic [6:0]    start_level;
	logic [6:0]    stop_level;
	logic          levels_custom;
	logic          fault_clear;
	logic          state_change;
	logic          tick;
	logic [7:0]    seconds;
	logic [7:0]    flame_seconds;
	logic          flame_seen;
	logic          proven;
	logic [7:0]    proven_seconds;
	logic [7:0]    clean_seconds;
	logic [3:0]    interlock_fault;
	logic [3:0]    next_fault;
	logic          lit_request;
	logic          apb_write;
	logic          apb_read;
	logic [6:0]    act_start;
	logic [6:0]    act_stop;

	////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, unmapped addresses flag pslverr

	assign pready    = 1'b1;
	assign apb_write = psel && penable && pwrite;
	assign apb_read  = psel && !penable && !pwrite;
	assign pslverr   = psel && penable && !(paddr inside {REG_CONTROL, REG_PURGE_TIME, REG_LEVELS,
	                                                      REG_STATUS, REG_FAULT, REG_POSITION});

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clean_select  <= CLEAN_2S;
			large_model   <= 1'b0;
			purge_seconds <= PURGE_DEF_SEC;
			start_level   <= START_SMALL;
			stop_level    <= STOP_SMALL;
			levels_custom <= 1'b0;
			fault_clear   <= 1'b0;
		end else begin
			fault_clear <= 1'b0;
			if (apb_write) begin
				unique case (paddr)
					REG_CONTROL: begin
						clean_select <= pwdata[CTL_CLEAN_LSB +: 2];
						large_model  <= pwdata[CTL_LARGE_BIT];
						fault_clear  <= pwdata[CTL_FAULT_CLR];
					end
					REG_PURGE_TIME: begin
						purge_seconds <= pwdata[7:0];
					end
					REG_LEVELS: begin
						start_level   <= pwdata[6:0];
						stop_level    <= pwdata[14:8];
						levels_custom <= pwdata[16];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// read data registered in the setup cycle, valid in the access phase
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0;
		end else if (apb_read) begin
			unique case (paddr)
				REG_CONTROL:    prdata <= {28'h0, 1'b0, large_model, clean_select};
				REG_PURGE_TIME: prdata <= {24'h0, purge_seconds};
				REG_LEVELS:     prdata <= {15'h0, levels_custom, 1'b0, act_stop, 1'b0, act_start};
				REG_STATUS:     prdata <= {15'h0, state, seconds};
				REG_FAULT:      prdata <= {28'h0, fault_code};
				REG_POSITION:   prdata <= {25'h0, valve_command};
				default:        prdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start and stop levels, model defaults unless overridden

	always_comb begin
		if (levels_custom) begin
			act_start = start_level;
			act_stop  = stop_level;
		end else if (large_model) begin
			act_start = START_LARGE;
			act_stop  = STOP_LARGE;
		end else begin
			act_start = START_SMALL;
			act_stop  = STOP_SMALL;
		end
	end

	// hysteresis on the loop's requested position
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lit_request <= 1'b0;
		end else if (!heat_demand) begin
			lit_request <= 1'b0;
		end else if (loop_position >= act_start) begin
			lit_request <= 1'b1;
		end else if (loop_position <= act_stop) begin
			lit_request <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timers

	assign state_change = next_state != state;

	bss_second_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.clock   (clock),
		.rst_n   (rst_n),
		.restart (state_change),
		.tick    (tick),
		.seconds (seconds)
	);

	// own divider for flame time: a dropout restarts it, so each second is a full one
	bss_second_timer #(.TICK_CYCLES(TICK_CYCLES)) u_flame_timer (.clock(clock), .rst_n(rst_n),
		.restart(!flame_sense || !(state inside {ST_TRIAL, ST_FIRING})), .tick(), .seconds(flame_seconds));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flame_seen <= 1'b0;
		end else begin
			flame_seen <= flame_sense && state inside {ST_TRIAL, ST_FIRING};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			proven         <= 1'b0;
			proven_seconds <= 8'h0;
		end else if (state != ST_FIRING) begin
			proven         <= 1'b0;
			proven_seconds <= 8'h0;
		end else begin
			if (flame_seconds >= FLAME_PROVE_SEC) begin
				proven <= 1'b1;
			end
			if (proven && tick && proven_seconds != 8'hff) begin
				proven_seconds <= proven_seconds + 8'h1;
			end
		end
	end

	always_comb begin
		unique case (clean_select)
			CLEAN_2S: clean_seconds = CLEAN_2S_SEC;
			CLEAN_7S: clean_seconds = CLEAN_7S_SEC;
			default:  clean_seconds = 8'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// interlocks; blocked inlet and blower proof are not part of this check

	always_comb begin
		if (!switches.valve_closure_proof) begin
			interlock_fault = FLT_CLOSURE;
		end else if (!switches.low_water) begin
			interlock_fault = FLT_LOW_WATER;
		end else if (!switches.high_temp) begin
			interlock_fault = FLT_HIGH_TEMP;
		end else if (!switches.high_gas) begin
			interlock_fault = FLT_HIGH_GAS;
		end else if (!switches.low_gas) begin
			interlock_fault = FLT_LOW_GAS;
		end else begin
			interlock_fault = FLT_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequence

	always_comb begin
		next_state = state;
		next_fault = FLT_NONE;
		unique case (state)
			ST_OFF: begin
				if (front_switch && interlock_fault == FLT_NONE) begin
					next_state = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (interlock_fault != FLT_NONE) begin
					next_state = ST_OFF;
				end else if (lit_request) begin
					next_state = ST_PURGE;
				end
			end
			ST_PURGE: begin
				if (switches.purge_switch && switches.blower_proof && seconds >= purge_seconds) begin
					next_state = ST_IGN_POS;
				end
			end
			ST_IGN_POS: begin
				if (switches.ignition_switch) begin
					next_state = ST_CLEAN;
				end
			end
			ST_CLEAN: begin
				if (seconds >= clean_seconds) begin
					next_state = ST_PRE_IGN;
				end
			end
			ST_PRE_IGN: begin
				if (!switches.valve_closure_proof) begin
					next_state = ST_TRIAL;
				end
			end
			ST_TRIAL: begin
				if (!spark_sense && !flame_seen && seconds >= SPARK_LIMIT_SEC) begin
					next_state = ST_FAULT;
					next_fault = FLT_NO_SPARK;
				end else if (flame_seconds >= FLAME_PROVE_SEC) begin
					next_state = ST_FIRING;
				end else if (!flame_seen && seconds >= FLAME_WINDOW_SEC) begin
					next_state = ST_FAULT;
					next_fault = FLT_NO_FLAME;
				end
			end
			ST_FIRING: begin
				if (!flame_sense) begin
					next_state = ST_FAULT;
					next_fault = FLT_FLAME_LOST;
				end else if (!lit_request) begin
					next_state = ST_STANDBY;
				end
			end
			ST_FAULT: begin
				if (fault_clear) begin
					next_state = ST_OFF;
				end
			end
			default: begin
				next_state = ST_FAULT;
			end
		endcase
		// low water, high temperature and gas pressure interlocks abort any active step
		if (!(state inside {ST_OFF, ST_STANDBY, ST_FAULT}) && next_state != ST_FAULT) begin
			if (!switches.low_water || !switches.high_temp || !switches.high_gas || !switches.low_gas) begin
				next_state = ST_FAULT;
				next_fault = interlock_fault;
			end
		end
		if (!front_switch && state != ST_FAULT) begin
			next_state = ST_OFF;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// latched fault code; live interlock fault shown while off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fault_code <= FLT_NONE;
		end else if (next_state == ST_FAULT && state != ST_FAULT) begin
			fault_code <= next_fault;
		end else if (state == ST_OFF) begin
			fault_code <= front_switch ? interlock_fault : FLT_NONE;
		end else if (state == ST_PURGE && seconds >= purge_seconds) begin
			fault_code <= !switches.purge_switch ? FLT_PURGE_SW :
			              (!switches.blower_proof ? FLT_BLOWER_PRF : FLT_NONE);
		end else if (state == ST_IGN_POS) begin
			fault_code <= FLT_IGN_SW;
		end else if (state != ST_FAULT) begin
			fault_code <= FLT_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			relays        <= '0;
			valve_command <= VALVE_CLOSED;
		end else begin
			relays.ready_lamp        <= state == ST_STANDBY;
			relays.demand_lamp       <= heat_demand && state != ST_OFF;
			relays.blower_relay      <= state inside {ST_PURGE, ST_IGN_POS, ST_CLEAN,
			                                          ST_PRE_IGN, ST_TRIAL, ST_FIRING};
			relays.gas_shutoff_valve <= state inside {ST_PRE_IGN, ST_TRIAL, ST_FIRING};
			relays.igniter_relay     <= state inside {ST_CLEAN, ST_PRE_IGN} ||
			                            (state == ST_TRIAL && !(flame_seen && flame_seconds >= IGNITER_OFF_SEC));
			unique case (state)
				ST_PURGE:                                   valve_command <= VALVE_FULL;
				ST_IGN_POS, ST_CLEAN, ST_PRE_IGN, ST_TRIAL: valve_command <= VALVE_LOW_FIRE;
				ST_FIRING:                                  valve_command <= loop_position;
				default:                                    valve_command <= VALVE_CLOSED;
			endcase
		end
	end

	assign valve_display = valve_command;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			display_code             <= DSP_OFF;
			display_value            <= 32'h0;
			purge_active_status      <= 1'b0;
			light_off_attempt_status <= 1'b0;
			fire_confirmed_status    <= 1'b0;
		end else begin
			purge_active_status      <= state == ST_PURGE && switches.blower_proof;
			light_off_attempt_status <= state == ST_TRIAL;
			fire_confirmed_status    <= proven;
			display_value            <= 32'h0;
			unique case (state)
				ST_STANDBY: display_code <= DSP_STANDBY;
				ST_PURGE: begin
					display_code  <= switches.blower_proof ? DSP_PURGE : DSP_STARTING;
					display_value <= {24'h0, seconds};
				end
				ST_CLEAN:   display_code <= DSP_CLEANING;
				ST_PRE_IGN: display_code <= DSP_PRE_IGN;
				ST_TRIAL:   display_code <= DSP_TRIAL;
				ST_FIRING: begin
					if (proven && proven_seconds >= STRENGTH_SEC) begin
						display_code  <= DSP_DATE_TIME;
						display_value <= date_time;
					end else if (proven) begin
						display_code  <= DSP_STRENGTH;
						display_value <= {24'h0, flame_strength};
					end else begin
						display_code <= DSP_TRIAL;
					end
				end
				ST_FAULT: begin
					display_code  <= DSP_FAULT;
					display_value <= {28'h0, fault_code};
				end
				ST_IGN_POS: display_code <= DSP_STARTING;
				default:    display_code <= DSP_OFF;
			endcase
		end
	end

endmodule

// file: sim/bss_plant.sv
// plant model: interlock contacts, valve switches, spark and flame sensing
`timescale 1ns/1ps
module bss_plant
	import bss_pkg::*;
(
	// clock and bench controls
	input  wire logic          clock,
	input  wire logic [4:0]    open_mask,
	input  wire logic          inlet_blocked,
	input  wire logic          spark_ok,
	input  wire logic          flame_ok,
	// from the sequencer
	input  wire bss_relay_type relays,
	input  wire logic [6:0]    valve_command,
	input  wire logic          light_off_attempt_status,
	// sensed by the sequencer
	output bss_switch_type     switches,
	output logic               spark_sense,
	output logic               flame_sense
);
	initial begin
		switches = '0;
		spark_sense = 1'b0;
		flame_sense = 1'b0;
	end
	////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		switches.valve_closure_proof <= !open_mask[4] && !relays.gas_shutoff_valve;
		{switches.low_water, switches.high_temp, switches.high_gas, switches.low_gas} <= ~open_mask[3:0];
		switches.blocked_inlet <= !inlet_blocked;
		switches.blower_proof <= relays.blower_relay;
		switches.purge_switch <= valve_command == VALVE_FULL;
		switches.ignition_switch <= valve_command >= 7'h19 && valve_command <= 7'h23;
		spark_sense <= relays.igniter_relay && spark_ok;
		// no spark means no light-off either
		flame_sense <= relays.gas_shutoff_valve && flame_ok && spark_ok && (flame_sense || light_off_attempt_status);
	end
endmodule

// file: sim/bss_sequencer_monitor.sv
// assertion checker bound to the burner start sequencer
`timescale 1ns/1ps
module bss_sequencer_monitor
	import bss_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SECOND_CYCLES
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          rst_n,
	// watched signals
	input  wire logic          spark_sense,
	input  wire logic          flame_sense,
	input  wire bss_relay_type relays,
	input  wire logic [6:0]    valve_command,
	input  wire logic [6:0]    valve_display,
	input  wire logic [3:0]    display_code,
	input  wire logic          purge_active_status,
	input  wire logic          light_off_attempt_status,
	input  wire logic          fire_confirmed_status
);
	int unsigned flame_cnt;
	int unsigned dark_cnt;
	int unsigned quiet_cnt;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// cycle counts: unbroken flame, flameless trial, trial with neither spark nor flame
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flame_cnt <= 0;
			dark_cnt <= 0;
			quiet_cnt <= 0;
		end else begin
			flame_cnt <= flame_sense ? flame_cnt + 1 : 0;
			dark_cnt <= (light_off_attempt_status && !flame_sense) ? dark_cnt + 1 : 0;
			quiet_cnt <= (light_off_attempt_status && !flame_sense && !spark_sense) ? quiet_cnt + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////
	purge_outputs_a: assert property (purge_active_status |-> relays.blower_relay && valve_command == VALVE_FULL)
		else $error("purge without blower or full valve");
	display_copy_a: assert property (valve_display == valve_command)
		else $error("valve display differs from command");
	gas_blower_a: assert property (relays.gas_shutoff_valve |-> relays.blower_relay)
		else $error("gas valve open without blower");
	trial_status_a: assert property (light_off_attempt_status |-> relays.gas_shutoff_valve && display_code == DSP_TRIAL)
		else $error("trial status without gas valve");
	cleaning_spark_a: assert property (display_code == DSP_CLEANING |-> relays.igniter_relay && !relays.gas_shutoff_valve)
		else $error("cleaning not spark only");
	fault_safe_a: assert property (display_code == DSP_FAULT |-> !relays.gas_shutoff_valve && !relays.igniter_relay)
		else $error("fault with gas or igniter on");
	igniter_time_a: assert property (relays.igniter_relay |-> flame_cnt <= TICK_CYCLES + 4)
		else $error("igniter on too long after flame");
	proof_time_a: assert property ($rose(fire_confirmed_status) |-> flame_cnt >= 2 * TICK_CYCLES - 4)
		else $error("fire_confirmed_status too early");
	flame_window_a: assert property (dark_cnt <= 4 * TICK_CYCLES + 3)
		else $error("flame window overrun");
	spark_window_a: assert property (quiet_cnt <= 3 * TICK_CYCLES + 3)
		else $error("trial kept without spark");
endmodule
bind bss_sequencer bss_sequencer_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_bss_sequencer_monitor (
	.clock, .rst_n, .spark_sense, .flame_sense, .relays, .valve_command, .valve_display,
	.display_code, .purge_active_status, .light_off_attempt_status, .fire_confirmed_status
);

// file: sim/burner_start_sequencer_bench.sv
// self-checking bench for the burner start sequencer
`timescale 1ns/1ps
module burner_start_sequencer_bench;
	import bss_pkg::*;
	localparam int unsigned TICK = 20;
	logic           clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic           front_switch, heat_demand, spark_sense, flame_sense, spark_ok, flame_ok, inlet_blocked;
	logic           purge_active_status, light_off_attempt_status, fire_confirmed_status;
	logic [7:0]     paddr, flame_strength;
	logic [31:0]    pwdata, prdata, date_time, display_value, rd;
	logic [6:0]     loop_position, valve_command, valve_display;
	logic [3:0]     display_code, fault_code;
	logic [4:0]     open_mask;
	bss_switch_type switches;
	bss_relay_type  relays;
	int             failures, total_checks, cycles, clean_cnt, purge_cnt, show_cnt;
	int             secs[3] = '{0, 2, 7};
	logic [1:0]     sels[3] = '{CLEAN_0S, CLEAN_2S, CLEAN_7S};

	bss_sequencer #(.TICK_CYCLES(TICK)) i_bss_sequencer (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .front_switch, .heat_demand, .switches, .spark_sense,
		.flame_sense, .flame_strength, .loop_position, .date_time, .relays, .valve_command, .valve_display,
		.display_code, .display_value, .fault_code, .purge_active_status, .light_off_attempt_status,
		.fire_confirmed_status);
	bss_plant i_bss_plant (.clock, .open_mask, .inlet_blocked, .spark_ok, .flame_ok, .relays,
		.valve_command, .light_off_attempt_status, .switches, .spark_sense, .flame_sense);

	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (failures == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// spans may land a few edges off the ideal count
	task automatic chk_time(input string what, input int exp, input int got);
		total_checks++;
		if (got < exp - 3 || got > exp + 3) begin
			failures++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
			output logic e);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask
	task automatic fire_up(input logic [1:0] sel);
		apb(1, REG_CONTROL, {30'h0, sel}, rd, err);
		clean_cnt = 0;
		purge_cnt = 0;
		show_cnt = 0;
		loop_position <= START_SMALL + 7'($urandom % 77);
		heat_demand <= 1;
		wait (purge_active_status === 1'b1);
		@(posedge clock);
		chk("purge outputs", {1'b1, VALVE_FULL, VALVE_FULL}, {relays.blower_relay, valve_command, valve_display});
		chk("demand lamp", 1, relays.demand_lamp);
		wait (relays.igniter_relay === 1'b1);
		@(posedge clock);
		chk_time("purge span", 2 * TICK, purge_cnt);
		chk("low fire", 1, valve_command >= 7'd25 && valve_command <= 7'd35);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (relays.igniter_relay === 1'b1 && relays.gas_shutoff_valve === 1'b0) clean_cnt++;
		if (purge_active_status === 1'b1) purge_cnt++;
		if (display_code === DSP_STRENGTH) show_cnt++;
		if (cycles > 30000) begin
			failures++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(19146));
		{psel, penable, pwrite, paddr, pwdata, front_switch, heat_demand, open_mask, inlet_blocked} = '0;
		{spark_ok, flame_ok} = 2'b11;
		loop_position = 7'h0;
		flame_strength = 8'($urandom);
		date_time = $urandom;
		rst_n = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1;
		@(posedge clock);
		chk("reset outputs", 0, {relays, valve_command, fault_code});
		apb(0, REG_PURGE_TIME, 0, rd, err);
		chk("purge time reset", {24'h0, PURGE_DEF_SEC}, rd);
		apb(0, 8'h20, 0, rd, err);
		chk("unmapped access", 32'h8000_0000, {err, rd[30:0]});
		apb(1, REG_PURGE_TIME, 32'h2, rd, err);
		front_switch <= 1;
		for (int i = 0; i < 5; i++) begin
			open_mask <= 5'h10 >> i;
			repeat (4) @(posedge clock);
			chk("interlock fault", {1'b0, 4'(FLT_CLOSURE + i)}, {relays.ready_lamp, fault_code});
			open_mask <= 5'h0;
			apb(1, REG_CONTROL, 32'h9, rd, err);
		end
		inlet_blocked <= 1;
		repeat (4) @(posedge clock);
		chk("ready standby", {1'b1, DSP_STANDBY}, {relays.ready_lamp, display_code});
		inlet_blocked <= 0;
		loop_position <= START_SMALL - 7'h1;
		heat_demand <= 1;
		repeat (6) @(posedge clock);
		chk("below start level", 0, relays.blower_relay);
		heat_demand <= 0;
		for (int i = 0; i < 3; i++) begin
			fire_up(sels[i]);
			wait (fire_confirmed_status === 1'b1);
			@(posedge clock);
			chk_time("cleaning span", secs[i] * TICK, clean_cnt);
			chk("strength value", {20'h0, DSP_STRENGTH, flame_strength}, {20'h0, display_code, display_value[7:0]});
			wait (display_code === DSP_DATE_TIME);
			@(posedge clock);
			chk_time("strength span", 5 * TICK, show_cnt);
			chk("date time", date_time, display_value);
			loop_position <= START_SMALL + 7'($urandom % 77);
			repeat (3) @(posedge clock);
			chk("valve follows loop", {loop_position, loop_position}, {valve_command, valve_display});
			if (i == 2) loop_position <= STOP_SMALL;
			else heat_demand <= 0;
			wait (display_code === DSP_STANDBY);
			@(posedge clock);
			chk("shut down", {3'b0, VALVE_CLOSED}, {relays[4:2], valve_command});
			heat_demand <= 0;
		end
		spark_ok <= 0;
		fire_up(CLEAN_0S);
		wait (display_code === DSP_FAULT);
		@(posedge clock);
		chk("no spark fault", FLT_NO_SPARK, fault_code);
		apb(0, REG_FAULT, 0, rd, err);
		chk("fault register", FLT_NO_SPARK, rd);
		heat_demand <= 0;
		spark_ok <= 1;
		flame_ok <= 0;
		apb(1, REG_CONTROL, 32'h8, rd, err);
		fire_up(CLEAN_0S);
		wait (display_code === DSP_FAULT);
		@(posedge clock);
		chk("no flame fault", {FLT_NO_FLAME, 2'b0}, {fault_code, relays.gas_shutoff_valve, relays.igniter_relay});
		complete_run();
	end
endmodule
